/* File: pkg/acc_b_pkg.sv */
// Purpose: shared constants and types for the accumulator and operand registers
// Assumes: 8-bit special function register space, one core clock
// Notes: offsets are the special function register addresses
package acc_b_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam int unsigned DATA_W = 8;
  localparam logic [7:0] ACC_ADDR = 8'hE0; // working_accumulator
  localparam logic [7:0] B_ADDR = 8'hF0; // multiplier_operand_reg
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] B_RESET = 8'h00;
  localparam logic [7:0] RDATA_IDLE = 8'h00; // read data for an unmapped address

  // ------------------------------------------------------------
  // execution operations requested by the instruction sequencer
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_NONE,
    OP_ACC_LOAD,
    OP_MUL,
    OP_DIV
  } exec_op_t;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } sfr_req_t;

  typedef struct packed {
    exec_op_t op;
    logic [7:0] result;
  } exec_req_t;

  typedef struct packed {
    logic valid;
    logic carry_flag;
    logic overflow_flag;
  } flag_upd_t;

endpackage

/* File: rtl/acc_b_muldiv.sv */
// Purpose: unsigned 8x8 multiply and 8/8 divide on the two operand registers
// Assumes: pure combinational; the caller registers the results
// Notes: quotient and remainder read as zero when the divisor is zero
`timescale 1ns/1ps
module acc_b_muldiv
  import acc_b_pkg::*;
#(
  parameter int unsigned WIDTH = DATA_W
) (
  input wire logic [WIDTH-1:0] i_acc,
  input wire logic [WIDTH-1:0] i_opb,
  output logic [2*WIDTH-1:0] o_product,
  output logic [WIDTH-1:0] o_quotient,
  output logic [WIDTH-1:0] o_remainder,
  output logic o_div_zero
);

  // ------------------------------------------------------------
  // arithmetic
  // ------------------------------------------------------------
  // product is formed at full width so no high bits are lost
  always_comb begin
    o_product = {{WIDTH{1'b0}}, i_acc} * {{WIDTH{1'b0}}, i_opb};
    o_div_zero = (i_opb == '0);
    if (o_div_zero) begin
      o_quotient = '0;
      o_remainder = '0;
    end else begin
      o_quotient = i_acc / i_opb;
      o_remainder = i_acc % i_opb;
    end
  end

endmodule

/* File: rtl/acc_b_regs.sv */
// Purpose: accumulator and multiplier operand registers of the processor core
// Assumes: sequencer presents one execution request per clock; core clock 40 MHz
// Notes: execution results win over a register-port write in the same cycle
`timescale 1ns/1ps
module acc_b_regs
  import acc_b_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire sfr_req_t i_sfr,
  input wire exec_req_t i_exec,
  output logic [7:0] o_sfr_rdata,
  output logic o_sfr_hit,
  output logic [7:0] o_acc,
  output logic [7:0] o_opb,
  output logic o_parity,
  output flag_upd_t o_flags
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] opb;
    logic parity;
    logic [7:0] rdata;
    logic hit;
    flag_upd_t flags;
  } state_t;

  state_t state_q;
  state_t state_d;

  logic [15:0] product;
  logic [7:0] quotient;
  logic [7:0] remainder;
  logic div_zero;
  logic acc_sel;
  logic opb_sel;

  // ------------------------------------------------------------
  // multiply / divide unit
  // ------------------------------------------------------------
  // operands are wired only from the two registers, no other source
  acc_b_muldiv #(
    .WIDTH(DATA_W)
  ) u_muldiv (
    .i_acc(state_q.acc),
    .i_opb(state_q.opb),
    .o_product(product),
    .o_quotient(quotient),
    .o_remainder(remainder),
    .o_div_zero(div_zero)
  );

  // register port address decode
  assign acc_sel = (i_sfr.addr == ACC_ADDR);
  assign opb_sel = (i_sfr.addr == B_ADDR);

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    state_d.flags.valid = 1'b0;
    // register port writes, then execution results override
    if (i_sfr.wr && acc_sel) begin
      state_d.acc = i_sfr.wdata;
    end
    if (i_sfr.wr && opb_sel) begin
      state_d.opb = i_sfr.wdata;
    end
    unique case (i_exec.op)
      OP_NONE: begin
      end
      OP_ACC_LOAD: begin
        state_d.acc = i_exec.result;
      end
      OP_MUL: begin
        // standard product split across the two registers
        state_d.acc = product[7:0];
        state_d.opb = product[15:8];
        state_d.flags.valid = 1'b1;
        state_d.flags.carry_flag = 1'b0;
        state_d.flags.overflow_flag = (product[15:8] != 8'h00);
      end
      OP_DIV: begin
        // a zero divisor leaves both registers untouched and flags overflow
        if (!div_zero) begin
          state_d.acc = quotient;
          state_d.opb = remainder;
        end
        state_d.flags.valid = 1'b1;
        state_d.flags.carry_flag = 1'b0;
        state_d.flags.overflow_flag = div_zero;
      end
    endcase
    // parity tracks the accumulator value being registered
    state_d.parity = ^state_d.acc;
    // read answer is one cycle after the strobe, old value on a same-cycle write
    state_d.hit = i_sfr.rd && (acc_sel || opb_sel);
    if (i_sfr.rd && acc_sel) begin
      state_d.rdata = state_q.acc;
    end else if (i_sfr.rd && opb_sel) begin
      state_d.rdata = state_q.opb;
    end else begin
      state_d.rdata = RDATA_IDLE;
    end
  end

  // state register
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state_q.acc <= ACC_RESET;
      state_q.opb <= B_RESET;
      state_q.parity <= 1'b0;
      state_q.rdata <= RDATA_IDLE;
      state_q.hit <= 1'b0;
      state_q.flags <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // outputs straight from flops
  assign o_acc = state_q.acc;
  assign o_opb = state_q.opb;
  assign o_parity = state_q.parity;
  assign o_sfr_rdata = state_q.rdata;
  assign o_sfr_hit = state_q.hit;
  assign o_flags = state_q.flags;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);

  acc_load_a: assert property (
    i_exec.op == OP_ACC_LOAD |=> o_acc == $past(i_exec.result)
  ) else $error("accumulator did not take the ALU result");

  acc_port_a: assert property (
    i_exec.op == OP_NONE && i_sfr.wr && i_sfr.addr == ACC_ADDR
      |=> o_acc == $past(i_sfr.wdata)
  ) else $error("accumulator port write lost");

  opb_scratch_a: assert property (
    i_exec.op == OP_NONE && i_sfr.wr && i_sfr.addr == B_ADDR
      |=> o_opb == $past(i_sfr.wdata)
  ) else $error("operand register port write lost");

  mul_split_a: assert property (
    i_exec.op == OP_MUL |=> {o_opb, o_acc} == 16'($past(o_acc)) * 16'($past(o_opb))
  ) else $error("multiply product misplaced");

  div_quot_a: assert property (
    i_exec.op == OP_DIV && o_opb != 8'h00 |=> o_acc == $past(o_acc) / $past(o_opb)
  ) else $error("divide quotient wrong");

  div_rem_a: assert property (
    i_exec.op == OP_DIV && o_opb != 8'h00 |=> o_opb == $past(o_acc) % $past(o_opb)
  ) else $error("divide remainder wrong");

  muldiv_flags_a: assert property (
    (i_exec.op == OP_MUL || i_exec.op == OP_DIV)
      |=> o_flags.valid && !o_flags.carry_flag
      ##1 (!o_flags.valid || $past(i_exec.op) == OP_MUL || $past(i_exec.op) == OP_DIV)
  ) else $error("flag update missing or carry not cleared");

  mul_ovf_a: assert property (
    i_exec.op == OP_MUL |=> o_flags.overflow_flag == (o_opb != 8'h00)
  ) else $error("multiply overflow wrong");

  div_ovf_a: assert property (
    i_exec.op == OP_DIV |=> o_flags.overflow_flag == ($past(o_opb) == 8'h00)
  ) else $error("divide overflow wrong");

  div_zero_hold_a: assert property (
    i_exec.op == OP_DIV && o_opb == 8'h00 |=> $stable(o_acc) && $stable(o_opb)
  ) else $error("divide by zero changed the registers");

  parity_track_a: assert property (
    o_parity == ^o_acc
  ) else $error("parity does not match accumulator");

  read_back_a: assert property (
    i_sfr.rd && i_sfr.addr == B_ADDR |=> o_sfr_hit && o_sfr_rdata == $past(o_opb)
  ) else $error("operand register read wrong");

  hold_idle_a: assert property (
    i_exec.op == OP_NONE && !i_sfr.wr |=> $stable(o_acc) && $stable(o_opb)
  ) else $error("registers changed without cause");

endmodule

/* File: bench/acc_b_regs_tb.sv */
// Purpose: self-checking bench for the accumulator and operand registers
// Assumes: requests driven at the rising edge, outputs sampled at the falling edge
// Notes: each request is followed by one idle cycle
`timescale 1ns/1ps
module acc_b_regs_tb
  import acc_b_pkg::*;
;
  // ------------------------------------------------------------
  // signals and design
  // ------------------------------------------------------------
  logic i_clock = 1'b0;
  logic i_rst;
  sfr_req_t special_function_register;
  exec_req_t exe;
  logic [7:0] rdata, acc, opb;
  logic hit, par;
  flag_upd_t flags;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;

  acc_b_regs u_acc_b_regs (
    .i_clock(i_clock), .i_rst(i_rst), .i_sfr(special_function_register), .i_exec(exe), .o_sfr_rdata(rdata),
    .o_sfr_hit(hit), .o_acc(acc), .o_opb(opb), .o_parity(par), .o_flags(flags)
  );

  // 25 ns core clock
  initial begin
    forever #12.5 i_clock = ~i_clock;
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check_val(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // parity is expected from the accumulator value
  task automatic check_regs(input logic [7:0] a, input logic [7:0] b);
    check_val(acc, a, "accumulator");
    check_val(opb, b, "operand register");
    check_val({7'h00, par}, {7'h00, ^a}, "parity");
  endtask

  task automatic cycle(input sfr_req_t s, input exec_req_t e);
    @(posedge i_clock);
    special_function_register <= s;
    exe <= e;
    @(posedge i_clock);
    special_function_register <= '0;
    exe <= '0;
    @(negedge i_clock);
  endtask

  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    cycle('{a, 1'b1, 1'b0, d}, '0);
  endtask

  task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp, input logic exp_hit);
    cycle('{a, 1'b0, 1'b1, 8'h00}, '0);
    check_val(rdata, exp, "read data");
    check_val({7'h00, hit}, {7'h00, exp_hit}, "read hit");
  endtask

  // result byte is junk for mul and div: it must not be used
  task automatic run_op(input exec_op_t op, input logic [7:0] res, input logic [7:0] a,
      input logic [7:0] b, input logic ov);
    cycle('0, '{op, res});
    check_regs(a, b);
    if (op == OP_MUL || op == OP_DIV) begin
      check_val({6'h00, flags.valid, flags.carry_flag}, 8'h02, "flag pulse");
      check_val({7'h00, flags.overflow_flag}, {7'h00, ov}, "overflow");
    end
  endtask

  // hang guard
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      mismatches++;
      complete_run();
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    i_rst <= 1'b1;
    special_function_register <= '0;
    exe <= '0;
    repeat (6) @(posedge i_clock);
    i_rst <= 1'b0;
    @(negedge i_clock);
    check_regs(ACC_RESET, B_RESET);
    sfr_wr(B_ADDR, 8'h5A);
    check_regs(8'h00, 8'h5A);
    sfr_rd(B_ADDR, 8'h5A, 1'b1);
    @(negedge i_clock);
    check_val(rdata, RDATA_IDLE, "idle read data");
    sfr_wr(ACC_ADDR, 8'h07);
    sfr_rd(ACC_ADDR, 8'h07, 1'b1);
    check_regs(8'h07, 8'h5A);
    // unmapped place: write ignored, read refused
    sfr_wr(8'hE1, 8'hFF);
    sfr_rd(8'hE1, RDATA_IDLE, 1'b0);
    check_regs(8'h07, 8'h5A);
    run_op(OP_ACC_LOAD, 8'h20, 8'h20, 8'h5A, 1'b0);
    sfr_wr(B_ADDR, 8'h10);
    run_op(OP_MUL, 8'hFF, 8'h00, 8'h02, 1'b1);
    @(negedge i_clock);
    check_val({7'h00, flags.valid}, 8'h00, "flag pulse end");
    run_op(OP_ACC_LOAD, 8'h0D, 8'h0D, 8'h02, 1'b0);
    run_op(OP_MUL, 8'h00, 8'h1A, 8'h00, 1'b0);
    run_op(OP_ACC_LOAD, 8'h64, 8'h64, 8'h00, 1'b0);
    sfr_wr(B_ADDR, 8'h07);
    run_op(OP_DIV, 8'h33, 8'h0E, 8'h02, 1'b0);
    sfr_wr(B_ADDR, 8'h00);
    run_op(OP_DIV, 8'h00, 8'h0E, 8'h00, 1'b1);
    // execution result beats a same-cycle port write
    cycle('{ACC_ADDR, 1'b1, 1'b0, 8'h55}, '{OP_ACC_LOAD, 8'h81});
    check_regs(8'h81, 8'h00);
    // reset in mid-run, then the registers must work again after release
    @(posedge i_clock);
    i_rst <= 1'b1;
    @(negedge i_clock);
    check_regs(ACC_RESET, B_RESET);
    check_val({5'h00, flags}, 8'h00, "flags after reset");
    check_val({7'h00, hit}, 8'h00, "hit after reset");
    repeat (2) @(posedge i_clock);
    i_rst <= 1'b0;
    @(negedge i_clock);
    check_regs(ACC_RESET, B_RESET);
    sfr_wr(ACC_ADDR, 8'h3C);
    check_regs(8'h3C, 8'h00);
    complete_run();
  end
endmodule
